// ---- lbx_exec.sv ----
/*
 * Execution core for AND-literal, AND-file, bit-clear and the carry and
 * sign relative branches, sequenced in four quarter-cycles.
 * Assumes program memory returns progData for progAddr the cycle after
 * instruction start, and the data file answers reads combinationally.
 */
module lbx_exec import lbx_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [15:0] progData,
    input wire logic [7:0] fileRdData,
    input wire logic [3:0] bankSelIn,
    input wire logic bankSelLoad,
    input wire logic carryIn,
    input wire logic carryLoad,
    output logic [20:0] progAddr,
    output logic [11:0] fileAddr,
    output logic [7:0] fileWrData,
    output logic fileWrEn,
    output logic [7:0] wregOut,
    output logic signFlag,
    output logic zeroFlag,
    output logic carryFlag,
    output logic [1:0] qPhase,
    output logic flushing
);
    // =========================================================
    // state
    logic [1:0] q_reg;
    logic [20:0] pc_reg, pc_next;
    logic [15:0] ir_reg;
    logic [7:0] w_reg, w_next;
    logic n_reg, n_next, z_reg, z_next, c_reg;
    logic [3:0] bank_reg;
    logic [7:0] fwd_reg, fwd_next;
    logic fwe_reg, fwe_next;
    lbx_state_t st_reg, st_next;
    lbx_inst_t kind;
    logic [11:0] dataAddr;

    lbx_decode u_dec (
        .instr(ir_reg),
        .kind(kind)
    );

    lbx_addr u_addr (
        .fileAddr(ir_reg[7:0]),
        .accBit(ir_reg[LBX_ACC_BIT]),
        .bankSel(bank_reg),
        .addr(dataAddr)
    );

    // =========================================================
    // datapath decode, continuous
    wire q4 = (q_reg == LBX_Q4);
    wire running = (st_reg == LBX_RUN);
    wire [7:0] andLit = w_reg & ir_reg[7:0];
    wire [7:0] andFile = w_reg & fileRdData;
    wire [7:0] bitMask = 8'h01 << ir_reg[LBX_BIDX_LSB +: 3];
    wire [7:0] clrVal = fileRdData & ~bitMask;
    wire [20:0] brOffset = {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
    wire [20:0] brTarget = pc_reg + brOffset;
    wire takeBr = (kind == LBX_I_BC && c_reg) || (kind == LBX_I_BN && n_reg);
    wire destFile = ir_reg[LBX_DEST_BIT];

    // next-state logic evaluated for the Q4 write-back
    always_comb begin
        w_next = w_reg;
        n_next = n_reg;
        z_next = z_reg;
        fwd_next = fwd_reg;
        fwe_next = 1'b0;
        pc_next = pc_reg + 21'h000002;
        st_next = LBX_RUN;
        if (running) begin
            case (kind)
                LBX_I_ANDL: begin
                    w_next = andLit;
                    n_next = andLit[7];
                    z_next = (andLit == 8'h00);
                end
                LBX_I_ANDF: begin
                    n_next = andFile[7];
                    z_next = (andFile == 8'h00);
                    if (destFile) begin
                        fwd_next = andFile;
                        fwe_next = 1'b1;
                    end else begin
                        w_next = andFile;
                    end
                end
                LBX_I_BCLR: begin
                    fwd_next = clrVal;
                    fwe_next = 1'b1;
                end
                LBX_I_BC, LBX_I_BN: begin
                    if (takeBr) begin
                        pc_next = brTarget;
                        st_next = LBX_FLUSH;
                    end
                end
                default: begin
                    w_next = w_reg;
                end
            endcase
        end else begin
            pc_next = pc_reg + 21'h000002;
        end
    end

    // quarter-cycle counter; W, N, Z, the pc and the instruction register change only at Q4
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q_reg <= LBX_Q1;
        end else begin
            q_reg <= q_reg + 2'h1;
        end
    end

    // architectural state; the flush cycle discards the fetched word
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pc_reg <= LBX_PC_RST;
            ir_reg <= 16'h0000;
            w_reg <= LBX_WREG_RST;
            n_reg <= 1'b0;
            z_reg <= 1'b0;
            st_reg <= LBX_RUN;
            fwd_reg <= 8'h00;
            fwe_reg <= 1'b0;
        end else begin
            fwe_reg <= 1'b0;
            if (q4) begin
                pc_reg <= pc_next;
                w_reg <= w_next;
                n_reg <= n_next;
                z_reg <= z_next;
                st_reg <= st_next;
                fwd_reg <= fwd_next;
                fwe_reg <= fwe_next;
                // a taken branch loads a nop word so the next cycle does nothing
                ir_reg <= (st_next == LBX_FLUSH) ? 16'h0000 : progData;
            end
        end
    end

    // carry and bank-select are owned elsewhere; loads take effect in any quarter
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            c_reg <= 1'b0;
            bank_reg <= LBX_BANK_RST;
        end else begin
            if (carryLoad) begin
                c_reg <= carryIn;
            end
            if (bankSelLoad) begin
                bank_reg <= bankSelIn;
            end
        end
    end

    // address is the decoded file address, registered; in the cycle after Q4 it still
    // holds the address of the instruction just retired, which is the write address
    logic [11:0] fileAddr_reg;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fileAddr_reg <= 12'h000;
        end else begin
            fileAddr_reg <= dataAddr;
        end
    end

    // =========================================================
    // outputs, all straight from flops except flushing, decoded from st_reg
    assign progAddr = pc_reg;
    assign fileAddr = fileAddr_reg;
    assign fileWrData = fwd_reg;
    assign fileWrEn = fwe_reg;
    assign wregOut = w_reg;
    assign signFlag = n_reg;
    assign zeroFlag = z_reg;
    assign carryFlag = c_reg;
    assign qPhase = q_reg;
    assign flushing = (st_reg == LBX_FLUSH);

    // =========================================================
    // checks
    chk_andl_result: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q4 && running && kind == LBX_I_ANDL) |=> (w_reg == ($past(w_reg) & $past(ir_reg[7:0]))))
        else $error("and-literal result wrong");
    chk_andl_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ir_reg[15:8] == 8'h0B) |-> (kind == LBX_I_ANDL))
        else $error("and-literal not decoded");
    chk_andf_dest: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q4 && running && kind == LBX_I_ANDF && destFile) |=> (fileWrEn && w_reg == $past(w_reg)))
        else $error("and-file destination wrong");
    chk_shared_bank: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!ir_reg[LBX_ACC_BIT] && !ir_reg[7]) |-> (dataAddr[11:8] == 4'h0))
        else $error("shared bank address wrong");
    chk_andf_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ir_reg[15:10] == 6'h05) |-> (kind == LBX_I_ANDF))
        else $error("and-file not decoded");
    chk_bc_notaken: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q4 && running && kind == LBX_I_BC && !c_reg) |=> (pc_reg == $past(pc_reg) + 21'h000002))
        else $error("branch taken without carry");
    chk_br_target: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q4 && running && takeBr) |=>
        (pc_reg == $past(pc_reg) + {{12{$past(ir_reg[7])}}, $past(ir_reg[7:0]), 1'b0}))
        else $error("branch target wrong");
    chk_flush_len: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q4 && running && takeBr) |=> flushing [*4] ##1 !flushing)
        else $error("flush cycle length wrong");
    chk_bclr_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q4 && running && kind == LBX_I_BCLR) |=> (fileWrEn && fileWrData[$past(ir_reg[11:9])] == 1'b0))
        else $error("bit clear left bit set");
    chk_flags_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q4 && (kind == LBX_I_BCLR || kind == LBX_I_BC || kind == LBX_I_BN)) |=> $stable(n_reg) && $stable(z_reg))
        else $error("flags changed");
    cov_br_taken: cover property (@(posedge sys_clk) disable iff (!rstn) q4 && running && takeBr);
    cov_andf_w: cover property (@(posedge sys_clk) disable iff (!rstn) q4 && kind == LBX_I_ANDF && !destFile);
    cov_bclr: cover property (@(posedge sys_clk) disable iff (!rstn) q4 && running && kind == LBX_I_BCLR);
    cov_br_untaken: cover property (@(posedge sys_clk) disable iff (!rstn) q4 && running && kind == LBX_I_BC && !c_reg);
    // extra decode, bank, and-file and branch checks; decoding is cheap to break when opcodes are added
    chk_bc_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ir_reg[15:8] == 8'hE2) |-> (kind == LBX_I_BC))
        else $error("branch-on-carry not decoded");
    chk_bn_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ir_reg[15:8] == 8'hE6) |-> (kind == LBX_I_BN))
        else $error("branch-on-sign not decoded");
    chk_bclr_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ir_reg[15:12] == 4'h9) |-> (kind == LBX_I_BCLR))
        else $error("bit-clear not decoded");
    chk_bank_select: assert property (@(posedge sys_clk) disable iff (!rstn)
        ir_reg[LBX_ACC_BIT] |-> (dataAddr == {bank_reg, ir_reg[7:0]}))
        else $error("bank-select address wrong");
    chk_andf_wdest: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q4 && running && kind == LBX_I_ANDF && !destFile) |=>
        (!fileWrEn && w_reg == ($past(w_reg) & $past(fileRdData))))
        else $error("and-file to W wrong");
    chk_bn_notaken: assert property (@(posedge sys_clk) disable iff (!rstn)
        (q4 && running && kind == LBX_I_BN && !n_reg) |=> (pc_reg == $past(pc_reg) + 21'h000002))
        else $error("branch taken without sign");
endmodule // lbx_exec

// ---- lbx_pkg.sv ----
/*
 * Shared constants for the logic-and-branch execution block: opcode
 * patterns, field positions, quarter-cycle phases and reset values.
 * Assumes a single 125 MHz clock and 16-bit program words.
 */
package lbx_pkg;
    // =========================================================
    // opcode patterns
    localparam logic [7:0] LBX_OP_AND_LIT = 8'h0B;
    localparam logic [5:0] LBX_OP_AND_FILE = 6'h05;
    localparam logic [7:0] LBX_OP_BR_CARRY = 8'hE2;
    localparam logic [7:0] LBX_OP_BR_SIGN = 8'hE6;
    localparam logic [3:0] LBX_OP_BIT_CLR = 4'h9;
    // =========================================================
    // instruction fields
    localparam int LBX_DEST_BIT = 9;
    localparam int LBX_ACC_BIT = 8;
    localparam int LBX_BIDX_LSB = 9;
    // =========================================================
    // reset values and widths
    localparam logic [7:0] LBX_WREG_RST = 8'h00;
    localparam logic [20:0] LBX_PC_RST = 21'h000000;
    localparam logic [3:0] LBX_BANK_RST = 4'h0;
    localparam logic [1:0] LBX_Q1 = 2'h0;
    localparam logic [1:0] LBX_Q4 = 2'h3;

    typedef enum logic [1:0] {LBX_RUN, LBX_FLUSH} lbx_state_t;
    typedef enum logic [2:0] {LBX_I_NONE, LBX_I_ANDL, LBX_I_ANDF, LBX_I_BC, LBX_I_BN, LBX_I_BCLR} lbx_inst_t;
endpackage

// ---- lbx_decode.sv ----
/*
 * Combinational decoder for the instruction group.
 * Assumes the fetched word is stable during the instruction cycle.
 */
module lbx_decode import lbx_pkg::*; (
    input wire logic [15:0] instr,
    output lbx_inst_t kind
);
    // =========================================================
    // pattern match on upper bits
    wire isAndL = (instr[15:8] == LBX_OP_AND_LIT);
    wire isAndF = (instr[15:10] == LBX_OP_AND_FILE);
    wire isBc = (instr[15:8] == LBX_OP_BR_CARRY);
    wire isBn = (instr[15:8] == LBX_OP_BR_SIGN);
    wire isBclr = (instr[15:12] == LBX_OP_BIT_CLR);
    assign kind = isAndL ? LBX_I_ANDL : isAndF ? LBX_I_ANDF : isBc ? LBX_I_BC :
                  isBn ? LBX_I_BN : isBclr ? LBX_I_BCLR : LBX_I_NONE;
endmodule // lbx_decode

// ---- lbx_addr.sv ----
/*
 * Data-memory address former: shared low bank or bank-select register.
 * Assumes access-bank lower half maps to 0x000..0x07F, upper to 0xF80..0xFFF.
 */
module lbx_addr import lbx_pkg::*; (
    input wire logic [7:0] fileAddr,
    input wire logic accBit,
    input wire logic [3:0] bankSel,
    output logic [11:0] addr
);
    // =========================================================
    // shared bank splits into low RAM and the top special-register page
    wire [11:0] sharedAddr = fileAddr[7] ? {4'hF, fileAddr} : {4'h0, fileAddr};
    assign addr = accBit ? {bankSel, fileAddr} : sharedAddr;
endmodule // lbx_addr

// ---- lbx_mem_model.sv ----
/*
 * Behavioural far side of the execution block: program store and data file.
 * Assumes the bench preloads both arrays while reset is held.
 */
module lbx_mem_model (
    input wire logic sys_clk,
    input wire logic [20:0] progAddr,
    input wire logic [11:0] fileAddr,
    input wire logic [7:0] fileWrData,
    input wire logic fileWrEn,
    output logic [15:0] progData,
    output logic [7:0] fileRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] prog [0:1023];
    logic [7:0] dmem [0:4095];
    // =========================================================
    // storage
    // reads answer at once; the byte bit of the pc is not a word index
    assign progData = prog[progAddr[10:1]];
    assign fileRdData = dmem[fileAddr];
    // writes land on the edge that sees the strobe
    always @(posedge sys_clk) begin
        if (fileWrEn === 1'b1) begin
            dmem[fileAddr] <= fileWrData;
        end
    end
endmodule // lbx_mem_model

// ---- tb_top.sv ----
/*
 * Self-checking bench: random programs run against an instruction-level model.
 * Assumes W can only be changed by the AND operations, so it stays at zero.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lbx_pkg::*;
    logic sys_clk, rstn, bankSelLoad, carryIn, carryLoad, fileWrEn, signFlag, zeroFlag, carryFlag, flushing;
    logic [15:0] progData;
    logic [7:0] fileRdData, fileWrData, wregOut;
    logic [3:0] bankSelIn;
    logic [20:0] progAddr;
    logic [1:0] qPhase, qExp;
    logic [11:0] fileAddr;
    logic [7:0] emem [0:4095];
    logic [31:0] seed = 32'h10;
    int miscompares = 0, total_checks = 0, flushCnt, taken;
    lbx_exec i_dut (.sys_clk(sys_clk), .rstn(rstn), .progData(progData), .fileRdData(fileRdData),
        .bankSelIn(bankSelIn), .bankSelLoad(bankSelLoad), .carryIn(carryIn), .carryLoad(carryLoad),
        .progAddr(progAddr), .fileAddr(fileAddr), .fileWrData(fileWrData), .fileWrEn(fileWrEn),
        .wregOut(wregOut), .signFlag(signFlag), .zeroFlag(zeroFlag), .carryFlag(carryFlag),
        .qPhase(qPhase), .flushing(flushing));
    lbx_mem_model i_mem (.sys_clk(sys_clk), .progAddr(progAddr), .fileAddr(fileAddr),
        .fileWrData(fileWrData), .fileWrEn(fileWrEn), .progData(progData), .fileRdData(fileRdData));
    // =========================================================
    // helpers
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // short forward branches only, so no random program can loop
    function logic [15:0] genWord();
        logic [31:0] r;
        r = xs();
        case (r[1:0])
            2'h0: return {LBX_OP_AND_LIT, r[15:8]};
            2'h1: return {LBX_OP_AND_FILE, r[9:8], r[23:16]};
            2'h2: return {LBX_OP_BIT_CLR, r[11:8], r[23:16]};
            default: return {r[5] ? 8'hE6 : (r[6] ? 8'hE2 : 8'hE3), 6'h00, r[8:7]};
        endcase
    endfunction
    function logic [11:0] effAddr(input logic [15:0] ins, input logic [3:0] bank);
        if (ins[LBX_ACC_BIT]) return {bank, ins[7:0]};
        return ins[7] ? {4'hF, ins[7:0]} : {4'h0, ins[7:0]};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask
    task summarize();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // =========================================================
    // clock, flush counter, watchdog
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (!rstn) flushCnt <= 0;
        else if (flushing === 1'b1) flushCnt <= flushCnt + 1;
    end
    // quarter phase must free-run from zero after reset; checked mid-cycle
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) qExp <= 2'h0;
        else qExp <= qExp + 2'h1;
    end
    always @(negedge sys_clk) begin
        if (rstn === 1'b1) chk(qPhase, qExp, "phase");
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end
    // =========================================================
    // one program run: long jump forward, long jump back, long jump forward again, random code between
    task run(input logic cin);
        logic [3:0] bank;
        logic [15:0] ins;
        logic [7:0] w, r;
        logic n, z;
        int pc, k, steps;
        rstn <= 1'b0;
        bank = 4'(xs());
        for (k = 0; k < 1024; k++) i_mem.prog[k] = ((k > 64 && k < 101) || (k > 127 && k < 192)) ? genWord() : 16'h0;
        i_mem.prog[0] = 16'hE27F;
        i_mem.prog[192] = 16'hE280;
        i_mem.prog[101] = 16'hE27F;
        i_mem.prog[70] = 16'hE300;
        for (k = 0; k < 4096; k++) begin
            emem[k] = 8'(xs());
            i_mem.dmem[k] = emem[k];
        end
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        {carryLoad, carryIn, bankSelLoad, bankSelIn} <= {1'b1, cin, 1'b1, bank};
        @(posedge sys_clk);
        {carryLoad, bankSelLoad} <= 2'b00;
        repeat (1600) @(posedge sys_clk);
        // instruction-level model of the same image
        {pc, steps, taken, w, n, z} = '0;
        while (pc < 256 && steps < 600) begin
            ins = i_mem.prog[pc];
            pc++;
            steps++;
            r = emem[effAddr(ins, bank)];
            if (ins[15:8] == LBX_OP_AND_LIT) {w, n, z} = {w & ins[7:0], w[7] & ins[7], (w & ins[7:0]) == 8'h0};
            else if (ins[15:10] == LBX_OP_AND_FILE) begin
                if (ins[LBX_DEST_BIT]) emem[effAddr(ins, bank)] = w & r;
                else w = w & r;
                {n, z} = {w[7] & r[7], (w & r) == 8'h0};
            end else if (ins[15:12] == LBX_OP_BIT_CLR) emem[effAddr(ins, bank)][ins[11:9]] = 1'b0;
            else if ((ins[15:8] == LBX_OP_BR_CARRY && cin) || (ins[15:8] == LBX_OP_BR_SIGN && n)) begin
                pc = pc + int'($signed(ins[7:0]));
                taken++;
            end
        end
        chk(wregOut, w, "W");
        chk({signFlag, zeroFlag, carryFlag}, {n, z, cin}, "flags");
        chk(flushCnt, 4 * taken, "flush clocks");
        for (k = 0; k < 4096; k++) chk(i_mem.dmem[k], emem[k], "file");
    endtask
    // =========================================================
    // main sequence: carry set takes all three long jumps, carry clear takes none
    initial begin
        {rstn, bankSelLoad, carryIn, carryLoad, bankSelIn} = '0;
        run(1'b1);
        run(1'b0);
        summarize();
    end
endmodule // tb_top
